/* verilog/lcdcd_pkg.sv */
// Package of constants and types for the LCD segment command decoder
package lcdcd_pkg;

  // ********************************************************
  // Register map (AHB-Lite word offsets)
  // ********************************************************
  localparam logic [7:0] OFF_STATUS   = 8'h00;
  localparam logic [7:0] OFF_MODE     = 8'h04;
  localparam logic [7:0] OFF_BLINK    = 8'h08;
  localparam logic [7:0] OFF_RAM_ADDR = 8'h0C;
  localparam logic [7:0] OFF_RAM_DATA = 8'h10;
  localparam logic [7:0] OFF_OUTPUT   = 8'h14;

  // ********************************************************
  // Command opcodes and fields
  // ********************************************************
  localparam logic [3:0] OPC_MODE_SET   = 4'hC;
  localparam logic [4:0] OPC_DEV_SELECT = 5'h1C;
  localparam logic [5:0] OPC_BANK_SEL   = 6'h3E;
  localparam logic [4:0] OPC_BLINK_SEL  = 5'h1E;
  localparam int         MODE_EN_BIT    = 3;
  localparam int         MODE_BIAS_BIT  = 2;
  localparam int         BANK_IN_BIT    = 1;
  localparam int         BANK_OUT_BIT   = 0;
  localparam int         BLINK_ALT_BIT  = 2;
  localparam int         CTRL_CONT_BIT  = 7;
  localparam int         CTRL_RS_BIT    = 6;
  localparam logic [6:0] SLAVE_ADDR_HI  = 7'h38;
  localparam logic [5:0] RAM_LAST_ADDR  = 6'h3B;

  // ********************************************************
  // Drive modes and reset values
  // ********************************************************
  localparam logic [1:0] DRV_1_4    = 2'h0;
  localparam logic [1:0] DRV_STATIC = 2'h1;
  localparam logic [1:0] DRV_1_2    = 2'h2;
  localparam logic [1:0] DRV_1_3    = 2'h3;
  localparam logic [1:0] RST_DRIVE  = 2'h0;
  localparam logic [6:0] RST_PTR    = 7'h00;
  localparam logic [2:0] RST_SUBADR = 3'h0;

  // ********************************************************
  // Blink dividers in display clock periods
  // ********************************************************
  localparam int BLINK_DIV1 = 768;
  localparam int BLINK_DIV2 = 1536;
  localparam int BLINK_DIV3 = 3072;
  localparam int DISP_CLK_HZ = 1970;
  localparam int SYS_CLK_HZ  = 10000000;
  localparam int DISP_DIV_CYCLES = SYS_CLK_HZ / DISP_CLK_HZ;

  // ********************************************************
  // Serial receiver states
  // ********************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_CTRL = 3'b011,
    ST_DATA = 3'b010,
    ST_ACK  = 3'b110,
    ST_SKIP = 3'b111
  } lcdcd_state_e;

endpackage : lcdcd_pkg

/* verilog/lcdcd_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module lcdcd_sync #(
  parameter logic RST_VAL = 1'b1
) (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Pin and filtered level
  input  wire logic pin_in,
  output logic      level_q
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } lcdcd_sync_s;

  lcdcd_sync_s st_q;
  lcdcd_sync_s st_d;

  // Level changes only when stages two and three agree
  always_comb begin
    st_d    = st_q;
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    if (st_q.s2 == st_q.s3) begin
      st_d.lvl = st_q.s3;
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= {4{RST_VAL}};
    end else begin
      st_q <= st_d;
    end
  end

  assign level_q = st_q.lvl;

endmodule : lcdcd_sync

/* verilog/lcdcd_top.sv */
// Command decoder and display controller of an LCD segment driver
// Operation
// - Byte 1100xxxx is mode-set; bit3 enables display
// - Display disabled blanks all outputs to supply
// - Mode-set bit2 picks third or half bias
// - Drive field: 01 static..00 four backplanes
// - Bit7 clear loads seven-bit data pointer
// - Byte 11100xxx loads subaddress counter
// - Bank-select bit1 is stored only; incoming display data path ignores it
// - Bank-select bit0 picks displayed RAM rows
// - Bank-select ignored in three/four backplane modes
// - Blink-select: bit2 alternate, bits1:0 rate
// - Three/four backplanes force normal blinking
// - Controller executes commands, fills display RAM
// - Slave receiver only; drives only acknowledges
// - Selection by address, subaddress, hardware pins
// - Data falling while clock high is start
// - Data rising while clock high is stop
// - Acknowledge every byte, unlimited byte count
// - Acknowledge holds data low whole high phase
// - Respond to 011100x write, x from pin
// - Control byte: continue bit, command/RAM select
// - Only matching subaddress acknowledges following bytes
// - Blink divides display clock 768/1536/3072
`timescale 1ns/1ps
module lcdcd_top #(
  parameter int RAM_WORDS   = 60,
  parameter int DISP_DIV    = lcdcd_pkg::DISP_DIV_CYCLES,
  parameter int BLINK_BASE  = lcdcd_pkg::BLINK_DIV1
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Serial bus pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // Address straps
  input  wire logic        address_select_pin,
  input  wire logic        hw_subaddr_pin0,
  input  wire logic        hw_subaddr_pin1,
  input  wire logic        hw_subaddr_pin2,
  // Display outputs
  output logic             blank_to_vlcd,
  output logic             blink_off_phase,
  output logic [1:0]       out_row_base
);

  // ********************************************************
  // State
  // ********************************************************
  typedef struct packed {
    lcdcd_pkg::lcdcd_state_e st;
    logic        scl_p;
    logic        sda_p;
    logic [2:0]  bitcnt;
    logic [7:0]  shreg;
    logic        ack_ok;
    logic        addr_ok;
    logic        in_ctrl;
    logic        cont;
    logic        rs;
    logic        ack_drive;
    logic        en;
    logic        bias_half;
    logic [1:0]  drive;
    logic [6:0]  ptr;
    logic [2:0]  subadr;
    logic        bank_in;
    logic        bank_out;
    logic        blink_alt;
    logic [1:0]  blink_rate;
    logic [15:0] disp_cnt;
    logic [11:0] blink_cnt;
    logic        blink_ph;
    logic        ahb_act;
    logic        ahb_wr;
    logic [7:0]  ahb_addr;
    logic [5:0]  ram_addr;
    logic [7:0]  byte_cnt;
    logic [31:0] rdata;
  } lcdcd_top_s;

  lcdcd_top_s s_q;
  lcdcd_top_s s_d;
  logic [3:0] ram_q [RAM_WORDS];
  logic       scl_s;
  logic       sda_s;
  logic       ram_we;
  logic [5:0] ram_wa;
  logic [3:0] ram_wd;

  // Synchronise serial pins
  // Both lines share one filter depth, so their relative timing is kept
  lcdcd_sync #(.RST_VAL(1'b1)) u_scl (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin_in  (scl_in),
    .level_q (scl_s)
  );
  lcdcd_sync #(.RST_VAL(1'b1)) u_sda (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin_in  (sda_in),
    .level_q (sda_s)
  );

  // Three- and four-backplane modes lack an alternate bank
  function automatic logic multi_row(input logic [1:0] m);
    multi_row = (m == lcdcd_pkg::DRV_1_3) || (m == lcdcd_pkg::DRV_1_4);
  endfunction : multi_row

  // Blink divider length in display clock periods
  function automatic logic [11:0] blink_len(input logic [1:0] r);
    case (r)
      2'h1:    blink_len = 12'(BLINK_BASE);
      2'h2:    blink_len = 12'(BLINK_BASE * 2);
      default: blink_len = 12'(BLINK_BASE * 4);
    endcase
  endfunction : blink_len

  logic [2:0] hw_sub;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  assign hw_sub   = {hw_subaddr_pin2, hw_subaddr_pin1, hw_subaddr_pin0};
  assign scl_rise = scl_s && !s_q.scl_p;
  assign scl_fall = !scl_s && s_q.scl_p;
  assign start_c  = scl_s && s_q.scl_p && s_q.sda_p && !sda_s;
  assign stop_c   = scl_s && s_q.scl_p && !s_q.sda_p && sda_s;

  // ********************************************************
  // Next-state logic
  // ********************************************************
  always_comb begin
    logic [7:0] b;
    logic       sel;
    b      = {s_q.shreg[6:0], sda_s};
    sel    = (s_q.subadr == hw_sub);
    s_d    = s_q;
    ram_we = 1'b0;
    ram_wa = s_q.ptr[5:0];
    ram_wd = 4'h0;
    s_d.scl_p = scl_s;
    s_d.sda_p = sda_s;

    // Serial receiver; bits sampled on clock rise, stable while high
    if (start_c) begin
      s_d.st     = lcdcd_pkg::ST_ADDR;
      s_d.bitcnt = 3'h0;
      s_d.ack_drive = 1'b0;
    end else if (stop_c) begin
      s_d.st        = lcdcd_pkg::ST_IDLE;
      s_d.ack_drive = 1'b0;
    end else begin
      case (s_q.st)
        lcdcd_pkg::ST_ADDR, lcdcd_pkg::ST_CTRL, lcdcd_pkg::ST_DATA: begin
          if (scl_rise) begin
            s_d.shreg  = b;
            s_d.bitcnt = s_q.bitcnt + 3'h1;
            if (s_q.bitcnt == 3'h7) begin
              s_d.ack_ok = 1'b0;
              if (s_q.st == lcdcd_pkg::ST_ADDR) begin
                // Write to 011100x only; reads ignored
                s_d.addr_ok = (b[7:1] == {lcdcd_pkg::SLAVE_ADDR_HI[6:1],
                               address_select_pin}) && !b[0];
                s_d.ack_ok  = s_d.addr_ok;
                s_d.in_ctrl = 1'b1;
              end else if (s_q.st == lcdcd_pkg::ST_CTRL) begin
                s_d.cont    = b[lcdcd_pkg::CTRL_CONT_BIT];
                s_d.rs      = b[lcdcd_pkg::CTRL_RS_BIT];
                s_d.in_ctrl = 1'b0;
                s_d.ack_ok  = sel;
              end else begin
                s_d.in_ctrl = s_q.cont;
                if (!s_q.rs) begin
                  // Commands are decoded by every addressed device
                  s_d.ack_ok = sel;
                  if (!b[7]) begin
                    s_d.ptr = b[6:0];
                  end else if (b[7:4] == lcdcd_pkg::OPC_MODE_SET) begin
                    s_d.en        = b[lcdcd_pkg::MODE_EN_BIT];
                    s_d.bias_half = b[lcdcd_pkg::MODE_BIAS_BIT];
                    s_d.drive     = b[1:0];
                  end else if (b[7:3] == lcdcd_pkg::OPC_DEV_SELECT) begin
                    s_d.subadr = b[2:0];
                    s_d.ack_ok = (b[2:0] == hw_sub);
                  end else if (b[7:2] == lcdcd_pkg::OPC_BANK_SEL) begin
                    if (!multi_row(s_q.drive)) begin
                      s_d.bank_in  = b[lcdcd_pkg::BANK_IN_BIT];
                      s_d.bank_out = b[lcdcd_pkg::BANK_OUT_BIT];
                    end
                  end else if (b[7:3] == lcdcd_pkg::OPC_BLINK_SEL) begin
                    s_d.blink_alt  = b[lcdcd_pkg::BLINK_ALT_BIT];
                    s_d.blink_rate = b[1:0];
                  end
                end else if (sel) begin
                  // Display byte: low nibble into RAM at pointer
                  s_d.ack_ok = 1'b1;
                  ram_we = (s_q.ptr[5:0] <= lcdcd_pkg::RAM_LAST_ADDR);
                  ram_wd = s_q.bank_in ? {b[3:2], b[1:0]} : b[3:0];
                  if (s_q.ptr[5:0] == lcdcd_pkg::RAM_LAST_ADDR) begin
                    s_d.ptr    = lcdcd_pkg::RST_PTR;
                    s_d.subadr = s_q.subadr + 3'h1;
                  end else begin
                    s_d.ptr = s_q.ptr + 7'h01;
                  end
                end
              end
              s_d.byte_cnt = s_q.byte_cnt + 8'h01;
              s_d.st       = lcdcd_pkg::ST_ACK;
            end
          end
        end
        lcdcd_pkg::ST_ACK: begin
          // Pull data low from clock fall through the ninth pulse
          if (scl_fall) begin
            if (!s_q.ack_drive && s_q.bitcnt == 3'h0) begin
              // First fall ends the eighth bit; pull low only if selected
              s_d.ack_drive = s_q.ack_ok;
              s_d.bitcnt    = 3'h1;
            end else begin
              // Second fall ends the acknowledge pulse; an unacknowledged
              // byte must leave here too, or the rest of the frame is lost
              s_d.ack_drive = 1'b0;
              s_d.bitcnt    = 3'h0;
              s_d.st = !s_q.addr_ok ? lcdcd_pkg::ST_SKIP :
                       (s_q.in_ctrl ? lcdcd_pkg::ST_CTRL : lcdcd_pkg::ST_DATA);
            end
          end
        end
        default: begin
          s_d.st = s_q.st;   // Idle or skip until the next start
        end
      endcase
    end

    // Display clock divider and blink phase
    // With blinking off the phase is parked low, so a rate set from
    // blinking off starts from the visible half period
    if (s_q.disp_cnt >= 16'(DISP_DIV - 1)) begin
      s_d.disp_cnt = 16'h0000;
      if (s_q.blink_rate == 2'h0) begin
        s_d.blink_cnt = 12'h000;
        s_d.blink_ph  = 1'b0;
      end else if (s_q.blink_cnt >= (blink_len(s_q.blink_rate) >> 1) - 12'h001) begin
        s_d.blink_cnt = 12'h000;
        s_d.blink_ph  = !s_q.blink_ph;
      end else begin
        s_d.blink_cnt = s_q.blink_cnt + 12'h001;
      end
    end else begin
      s_d.disp_cnt = s_q.disp_cnt + 16'h0001;
    end

    // AHB-Lite: capture address phase, answer in the data phase
    // No wait states: read data is registered at the address phase, so it
    // stands for the whole data phase and until the next read
    s_d.ahb_act = hsel && hready && htrans[1];
    if (hsel && hready && htrans[1]) begin
      s_d.ahb_wr   = hwrite;
      s_d.ahb_addr = haddr[7:0];
    end
    if (s_q.ahb_act && s_q.ahb_wr && s_q.ahb_addr == lcdcd_pkg::OFF_RAM_ADDR) begin
      s_d.ram_addr = hwdata[5:0];
    end
    if (hsel && hready && htrans[1] && !hwrite) begin
      if (haddr[7:0] == lcdcd_pkg::OFF_STATUS) begin
        s_d.rdata = {17'h0, s_q.st, s_q.byte_cnt, s_q.addr_ok, 3'h0};
      end else if (haddr[7:0] == lcdcd_pkg::OFF_MODE) begin
        s_d.rdata = {16'h0, 1'b0, s_q.ptr, s_q.subadr, s_q.en, s_q.bias_half,
                     s_q.drive, s_q.bank_in};
        s_d.rdata[16] = s_q.bank_out;
      end else if (haddr[7:0] == lcdcd_pkg::OFF_BLINK) begin
        s_d.rdata = {28'h0, s_q.blink_ph, s_q.blink_alt, s_q.blink_rate};
      end else if (haddr[7:0] == lcdcd_pkg::OFF_RAM_ADDR) begin
        s_d.rdata = {26'h0, s_q.ram_addr};
      end else if (haddr[7:0] == lcdcd_pkg::OFF_RAM_DATA) begin
        s_d.rdata = {28'h0, ram_q[s_q.ram_addr]};
      end else if (haddr[7:0] == lcdcd_pkg::OFF_OUTPUT) begin
        s_d.rdata = {29'h0, blank_to_vlcd, out_row_base};
      end else begin
        s_d.rdata = 32'h0000_0000;
      end
    end
  end

  // ********************************************************
  // Registers and display RAM
  // ********************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '{st: lcdcd_pkg::ST_IDLE, scl_p: 1'b1, sda_p: 1'b1,
               drive: lcdcd_pkg::RST_DRIVE, ptr: lcdcd_pkg::RST_PTR,
               subadr: lcdcd_pkg::RST_SUBADR, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // Display RAM written by the controller
  // No reset: contents are undefined until software fills them
  always_ff @(posedge hclk) begin
    if (ram_we) begin
      ram_q[ram_wa] <= ram_wd;
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  logic alt_eff;
  assign alt_eff = s_q.blink_alt && !multi_row(s_q.drive);

  // Open-drain data: only acknowledges are driven low
  // The pin is never driven high; the pull-up gives the released level
  assign sda_out   = 1'b0;
  assign sda_oe    = s_q.ack_drive;
  assign blank_to_vlcd   = !s_q.en;
  assign blink_off_phase = s_q.blink_ph && !alt_eff;
  assign out_row_base    = (multi_row(s_q.drive) ? 1'b0 :
                            (s_q.bank_out ^ (alt_eff && s_q.blink_ph))) ? 2'h2 : 2'h0;
  assign hrdata    = s_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule : lcdcd_top

/* sim/lcdcd_i2c_master.sv */
// Two-wire serial bus master model driving the decoder pins
`timescale 1ns/1ps
module lcdcd_i2c_master #(
  parameter int HALF = 12
) (
  // Clock and wire level
  input  wire logic hclk,
  input  wire logic sda_line,
  // Driven lines
  output logic      scl_o,
  output logic      sda_o
);
  // Idle bus at time zero
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Waits clock edges
  task automatic tick(input int k);
    repeat (k) @(posedge hclk);
  endtask : tick
  // Start, only from an idle bus with both lines high
  task automatic start();
    tick(HALF);
    sda_o <= 1'b0;
    tick(HALF);
    scl_o <= 1'b0;
  endtask : start
  // Stop ends the transfer
  task automatic stop();
    tick(2);
    sda_o <= 1'b0;
    tick(HALF);
    scl_o <= 1'b1;
    tick(HALF);
    sda_o <= 1'b1;
    tick(HALF);
  endtask : stop
  // Byte out MSB first, then a released line for the acknowledge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      tick(2);
      sda_o <= (i == 0) ? 1'b1 : b[i-1];
      tick(HALF);
      scl_o <= 1'b1;
      ack = 1'b1;
      // Acknowledge counts only if low for the whole high phase
      repeat (HALF) begin
        @(posedge hclk);
        if (sda_line !== 1'b0) ack = 1'b0;
      end
      scl_o <= 1'b0;
    end
  endtask : send_byte
endmodule : lcdcd_i2c_master

/* sim/lcdcd_top_assertions.sv */
// Port-level checks of the LCD command decoder
`timescale 1ns/1ps
module lcdcd_checker (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus side
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Serial and display side
  input wire logic        scl_in,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic [1:0]  out_row_base
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Acknowledge steps
  sequence s_ack_begin;
    $rose(sda_oe);
  endsequence
  sequence s_ack_end;
    ##[1:60] !sda_oe;
  endsequence
  // Bus answers
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_ready_high: assert property (hreadyout == 1'b1)
    else $error("bus wait inserted");
  a_rdata_hold: assert property ($changed(hrdata) |->
    $past(hsel) && $past(hready) && $past(htrans[1]) && !$past(hwrite))
    else $error("read data moved without a read");
  // Serial line driving
  a_oe_pulls_low: assert property (sda_oe |-> !sda_out)
    else $error("data line driven high");
  a_ack_in_low: assert property (s_ack_begin |-> !scl_in)
    else $error("acknowledge began in clock high phase");
  a_ack_holds: assert property (sda_oe && scl_in |=> sda_oe || !scl_in)
    else $error("acknowledge released in high phase");
  a_ack_ends: assert property (s_ack_begin |-> s_ack_end)
    else $error("acknowledge too long");
  // Display bank base
  a_row_even: assert property (out_row_base[0] == 1'b0)
    else $error("row base not 0 or 2");
endmodule : lcdcd_checker

bind lcdcd_top lcdcd_checker u_chk (
  .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hrdata, .hreadyout,
  .hresp, .scl_in, .sda_out, .sda_oe, .out_row_base
);

/* sim/lcdcd_bench.sv */
// Self-checking bench of the LCD command decoder
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected at %0t: got %0h exp %0h", $time, g, e); end end
module lcdcd_bench;
  localparam int DD = 4;
  localparam int BB = 8;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic        scl, sda_oe, sda_out, sda_line, m_sda, sel_pin, blank, phase, e, b;
  logic [1:0]  htrans, row;
  logic [2:0]  hsize, pins, r;
  logic [6:0]  p;
  logic [7:0]  d0, d1, d2;
  logic [7:0]  q[$];
  logic [15:0] ak;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          err_total, total_checks, n;

  // Bus ready and open-drain wire with pull-up
  assign hready = hreadyout;
  assign sda_line = m_sda & ~(sda_oe & ~sda_out);

  // Clock
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  lcdcd_top #(.DISP_DIV(DD), .BLINK_BASE(BB)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .address_select_pin(sel_pin), .hw_subaddr_pin0(pins[0]),
    .hw_subaddr_pin1(pins[1]), .hw_subaddr_pin2(pins[2]),
    .blank_to_vlcd(blank), .blink_off_phase(phase), .out_row_base(row)
  );
  lcdcd_i2c_master m (.hclk(hclk), .sda_line(sda_line), .scl_o(scl), .sda_o(m_sda));

  // Verdict and end of run
  task automatic print_verdict();
    if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  // Bounded wait for hready at a rising edge
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 50);
    if (k >= 50) begin
      err_total++;
      print_verdict();
    end
  endtask : wait_rdy
  // Single-word AHB-Lite transfer
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : ahb
  // Address byte, then the queued bytes; one acknowledge bit each
  task automatic send(input logic [7:0] adr);
    logic a;
    m.start();
    m.send_byte(adr, a);
    ak = {15'h0000, a};
    foreach (q[i]) begin
      m.send_byte(q[i], a);
      ak[i+1] = a;
    end
    m.stop();
  endtask : send
  // Half period, in cycles, of the blink phase
  task automatic measure(output int len);
    logic pv;
    int c;
    c = 0;
    len = 0;
    pv = phase;
    for (int k = 0; k < 900 && c < 3; k++) begin
      @(negedge hclk);
      len++;
      if (phase !== pv) begin
        c++;
        pv = phase;
        if (c < 3) len = 0;
      end
    end
    if (c < 3) begin
      err_total++;
      print_verdict();
    end
  endtask : measure
  // Expected slave address and blink half period
  function automatic logic [7:0] sadr(input logic s);
    return {6'b011100, s, 1'b0};
  endfunction : sadr
  function automatic int half_len(input int rate);
    return DD * BB * (1 << (rate - 1)) / 2;
  endfunction : half_len

  // ********************************************************
  // Main sequence
  // ********************************************************
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    err_total = 0;
    total_checks = 0;
    void'($urandom(32'h4A6D0C8A));
    sel_pin = 1'($urandom);
    pins = 3'($urandom);
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (5) @(posedge hclk);
    // Reset values, unmapped and read-only places
    ahb(1'b0, lcdcd_pkg::OFF_BLINK, 32'h0);
    `CHK(rd[2:0], 3'h0)
    ahb(1'b0, lcdcd_pkg::OFF_OUTPUT, 32'h0);
    `CHK(rd[2:0], 3'h4)
    ahb(1'b1, lcdcd_pkg::OFF_MODE, 32'hFFFFFFFF);
    ahb(1'b0, 8'h40, 32'h0);
    `CHK(rd, 32'h0)
    ahb(1'b0, lcdcd_pkg::OFF_MODE, 32'h0);
    `CHK(rd, 32'h0)
    // Subaddress, then a foreign address and a read address
    q = '{8'h00, {5'b11100, pins}};
    send(sadr(sel_pin));
    `CHK(ak[0], 1'b1)
    ahb(1'b0, lcdcd_pkg::OFF_MODE, 32'h0);
    `CHK(rd[7:5], pins)
    q = '{8'h00, 8'hC8};
    send(sadr(~sel_pin));
    `CHK(ak[0], 1'b0)
    send(sadr(sel_pin) | 8'h01);
    `CHK(ak[0], 1'b0)
    `CHK(blank, 1'b1)
    // Every drive mode, with pointer and blink in one transfer
    for (int d = 0; d < 4; d++) begin
      e = 1'($urandom);
      b = 1'($urandom);
      p = 7'($urandom_range(59));
      r = 3'($urandom);
      q = '{8'h00, {4'hC, e, b, d[1:0]}, {1'b0, p}, {5'b11110, r}};
      send(sadr(sel_pin));
      `CHK(ak[4:0], 5'h1F)
      ahb(1'b0, lcdcd_pkg::OFF_MODE, 32'h0);
      `CHK({rd[14:8], rd[4:1]}, {p, e, b, d[1:0]})
      `CHK(blank, ~e)
      ahb(1'b0, lcdcd_pkg::OFF_BLINK, 32'h0);
      `CHK(rd[2:0], r)
    end
    // Bank select in static and two-backplane modes, then in four
    for (int i = 0; i < 4; i++) begin
      q = '{8'h00, 8'hF0, {6'b110010, i[1], ~i[1]}, {6'b111110, i[1:0]}};
      send(sadr(sel_pin));
      ahb(1'b0, lcdcd_pkg::OFF_MODE, 32'h0);
      `CHK({rd[16], rd[0]}, {i[0], i[1]})
      `CHK(row, {i[0], 1'b0})
    end
    q = '{8'h00, 8'hC8, 8'hF8};
    send(sadr(sel_pin));
    ahb(1'b0, lcdcd_pkg::OFF_MODE, 32'h0);
    `CHK({rd[16], rd[0]}, 2'b11)
    // Blink rates with alternate bit set in four-backplane mode
    for (int i = 1; i < 4; i++) begin
      q = '{8'h00, {5'b11110, 1'b1, i[1:0]}};
      send(sadr(sel_pin));
      measure(n);
      `CHK(n, half_len(i))
    end
    // Alternate bank blinking in static mode swaps the shown rows
    q = '{8'h00, 8'hC9, 8'hF5};
    send(sadr(sel_pin));
    n = 0;
    e = 1'b0;
    repeat (40) begin
      @(negedge hclk);
      if (row == 2'h2) n++;
      if (phase !== 1'b0) e = 1'b1;
    end
    `CHK(n > 0 && n < 40, 1'b1)
    `CHK(e, 1'b0)
    q = '{8'h00, 8'hF0};
    send(sadr(sel_pin));
    repeat (100) @(posedge hclk);
    `CHK(phase, 1'b0)
    // Display data across the pointer wrap; next subaddress not ours
    d0 = 8'($urandom_range(127));
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    q = '{8'h80, 8'h3A, 8'h40, d0, d1, d2};
    send(sadr(sel_pin));
    `CHK(ak[6:0], 7'h3F)
    ahb(1'b0, lcdcd_pkg::OFF_MODE, 32'h0);
    `CHK({rd[14:8], rd[7:5]}, {7'h00, pins + 3'h1})
    ahb(1'b1, lcdcd_pkg::OFF_RAM_ADDR, 32'h3A);
    ahb(1'b0, lcdcd_pkg::OFF_RAM_DATA, 32'h0);
    `CHK(rd[3:0], d0[3:0])
    ahb(1'b1, lcdcd_pkg::OFF_RAM_ADDR, 32'h3B);
    ahb(1'b0, lcdcd_pkg::OFF_RAM_DATA, 32'h0);
    `CHK(rd[3:0], d1[3:0])
    print_verdict();
  end
endmodule : lcdcd_bench
